/* common/vmeri_regs.svh */
// clock and supervision times, channel layout and reset values of the requester block
// assumes the core clock figure below matches the i_core_clk rate
`ifndef VMERI_REGS_SVH
`define VMERI_REGS_SVH

// ==========================================================
// clock and supervision times
`define VMERI_CLK_KHZ 200000
`define VMERI_BREQ_TO_MS 1000
`define VMERI_WDOG_TO_MS 2500
`define VMERI_DMA_MAX_US 64

// ==========================================================
// command channel layout and values
`define VMERI_CHAN_AW 9
`define VMERI_CHAN_LAST 9'h1FF
`define VMERI_CHAN_FIRST 9'h000
`define VMERI_CHAN_READY 8'h01
`define VMERI_CHAN_CLEAR 8'h00

// ==========================================================
// reset values and the interrupt-off level
`define VMERI_STATUS_ID_RST 8'h00
`define VMERI_IRQ_LVL_NONE 3'h0

`endif

/* common/vmeri_pkg.sv */
// state types shared by the requester/interrupter block
// assumes no other package defines the same names
package vmeri_pkg;

	// ==========================================================
	// bus requester states
	typedef enum logic [2:0] {
		RQ_IDLE, RQ_PEND, RQ_SEIZE, RQ_OWN, RQ_PASS
	} vmeri_req_e;

	// ==========================================================
	// acknowledge daisy-chain states
	typedef enum logic [1:0] {IK_IDLE, IK_RESP, IK_PASS} vmeri_iack_e;

	// ==========================================================
	// reset, self-test and failure supervision states
	typedef enum logic [1:0] {
		SUP_TEST, SUP_CLEAR, SUP_RUN, SUP_FAIL
	} vmeri_sup_e;

endpackage : vmeri_pkg

/* hw/vmeri_timer.sv */
// run-time supervision counter: flags once i_run held LIMIT cycles
// assumes i_run drops to restart the count
`timescale 1ns/1ps

module vmeri_timer #(
	parameter int unsigned LIMIT = 4096
) (
	input wire logic i_core_clk, // core clock
	input wire logic i_sys_rst, // sync reset, high
	input wire logic i_run, // count while high
	output logic o_expired // limit reached, level
);
	localparam int unsigned W = $clog2(LIMIT + 1);

	// ==========================================================
	// elaboration check
	generate
		if (LIMIT < 1) begin : g_bad
			$error("vmeri_timer: LIMIT must be at least 1");
		end
	endgenerate

	logic [W-1:0] cnt;

	// ==========================================================
	// counter; a dropped run clears it so each wait starts afresh
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || !i_run) begin
			cnt <= '0;
			o_expired <= 1'b0;
		end else if (cnt == W'(LIMIT - 1)) begin
			o_expired <= 1'b1;
		end else begin
			cnt <= cnt + W'(1);
		end
	end

endmodule : vmeri_timer

/* hw/vmeri_top.sv */
// system-bus requester, interrupter and reset/self-test/failure watch
// assumes all inputs synchronous to i_core_clk; pin drivers outside
`timescale 1ns/1ps
`include "vmeri_regs.svh"

module vmeri_top #(
	parameter int unsigned BREQ_CYC = `VMERI_BREQ_TO_MS * `VMERI_CLK_KHZ,
	parameter int unsigned WDOG_CYC = `VMERI_WDOG_TO_MS * `VMERI_CLK_KHZ,
	parameter int unsigned DMA_CYC =
		`VMERI_DMA_MAX_US * `VMERI_CLK_KHZ / 1000
) (
	input wire logic i_core_clk, // core clock 200 MHz
	input wire logic i_sys_rst, // system reset, high
	input wire logic [1:0] i_arb_level, // arbitration jumper
	input wire logic [2:0] i_irq_level, // interrupt jumper, 0 off
	input wire logic i_sysfail_jmp, // route failure to bus
	input wire logic i_dma_req, // firmware DMA request
	input wire logic i_int_req, // firmware interrupt req
	input wire logic i_cfg_wr, // configuration command
	input wire logic [7:0] i_cfg_status_id, // status/ID byte
	input wire logic i_wdog_kick, // firmware watchdog restart
	input wire logic i_fw_fail, // firmware fatal fault
	input wire logic i_test_done, // self-test finished
	input wire logic i_test_fault, // self-test found fault
	input wire logic [3:0] i_bg_in_n, // grant chain in
	input wire logic i_as_n, // address strobe
	input wire logic i_iack_n, // acknowledge cycle
	input wire logic i_iackin_n, // ack chain in
	input wire logic [2:0] i_iack_lvl, // acknowledged level
	output logic [3:0] o_bg_out_n, // grant chain out
	output logic [3:0] o_br_o, // bus request value
	output logic [3:0] o_br_oe, // bus request drive
	output logic o_bbsy_o, // bus busy value
	output logic o_bbsy_oe, // bus busy drive
	output logic o_master_en, // master interface on
	output logic o_breq_abort, // request timeout pulse
	output logic o_dma_overrun, // DMA time limit hit
	output logic [7:1] o_irq_o, // interrupt value
	output logic [7:1] o_irq_oe, // interrupt drive
	output logic o_iackout_n, // ack chain out
	output logic [7:0] o_data_o, // status/ID byte
	output logic o_data_oe, // status/ID drive
	output logic o_sysfail_o, // system failure value
	output logic o_sysfail_oe, // system failure drive
	output logic o_fail_led, // front failure lamp
	output logic o_test_run, // self-test in progress
	output logic o_cmd_ready, // commands accepted
	output logic o_chan_we, // channel write strobe
	output logic [`VMERI_CHAN_AW-1:0] o_chan_addr, // channel address
	output logic [7:0] o_chan_data // channel write data
);

	// ==========================================================
	// elaboration checks
	generate
		if (BREQ_CYC < 1 || WDOG_CYC < 1 || DMA_CYC < 1) begin : g_bad
			$error("vmeri_top: timing counts must be at least 1");
		end
	endgenerate

	// value written at a channel location
	function automatic logic [7:0] chan_word(
		input logic [`VMERI_CHAN_AW-1:0] addr
	);
		chan_word = (addr == `VMERI_CHAN_LAST) ? `VMERI_CHAN_READY
			: `VMERI_CHAN_CLEAR;
	endfunction : chan_word

	vmeri_pkg::vmeri_req_e req_st;
	vmeri_pkg::vmeri_iack_e ik_st;
	vmeri_pkg::vmeri_sup_e sup_st;
	logic run;
	logic dma_go;
	logic bg_in;
	logic breq_exp;
	logic breq_exp_d;
	logic dma_exp;
	logic wdog_exp;
	logic irq_pend;
	logic int_req_d;
	logic int_set;
	logic iack_own;
	logic [7:0] status_id;

	// ==========================================================
	// local request gating: a stopped module raises no new DMA or interrupt request; pending ones stay driven
	assign run = (sup_st == vmeri_pkg::SUP_RUN);
	assign dma_go = i_dma_req && run;
	assign bg_in = !i_bg_in_n[i_arb_level];

	// ==========================================================
	// requester: bus clear and other requests are not inputs at
	// all, so a held bus is only given up when the work is done or the DMA limit is hit
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			req_st <= vmeri_pkg::RQ_IDLE;
		end else begin
			case (req_st)
				vmeri_pkg::RQ_IDLE: begin
					if (bg_in) begin
						req_st <= vmeri_pkg::RQ_PASS;
					end else if (dma_go) begin
						req_st <= vmeri_pkg::RQ_PEND;
					end
				end
				vmeri_pkg::RQ_PEND: begin
					if (bg_in) begin
						req_st <= vmeri_pkg::RQ_SEIZE;
					end
				end
				vmeri_pkg::RQ_SEIZE: begin
					if (i_as_n) begin
						req_st <= vmeri_pkg::RQ_OWN;
					end
				end
				vmeri_pkg::RQ_OWN: begin
					if ((!dma_go || o_dma_overrun) && !bg_in) begin
						req_st <= vmeri_pkg::RQ_IDLE;
					end
				end
				vmeri_pkg::RQ_PASS: begin
					if (!bg_in) begin
						req_st <= vmeri_pkg::RQ_IDLE;
					end
				end
				default: req_st <= vmeri_pkg::RQ_IDLE;
			endcase
		end
	end

	// ==========================================================
	// bus pins; unused levels pass their grant straight through
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (i[1:0] == i_arb_level) begin
				o_bg_out_n[i] = !(req_st == vmeri_pkg::RQ_PASS && bg_in);
				o_br_oe[i] = (req_st == vmeri_pkg::RQ_PEND) ||
					(req_st == vmeri_pkg::RQ_SEIZE);
			end else begin
				o_bg_out_n[i] = i_bg_in_n[i];
				o_br_oe[i] = 1'b0;
			end
		end
	end
	assign o_br_o = 4'h0;
	assign o_bbsy_o = 1'b0;
	assign o_bbsy_oe = (req_st == vmeri_pkg::RQ_OWN);
	assign o_master_en = (req_st == vmeri_pkg::RQ_OWN) && !o_dma_overrun;

	// ==========================================================
	// request supervision; the request stays on the bus after it
	vmeri_timer #(.LIMIT(BREQ_CYC)) u_breq_timer (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_run(req_st == vmeri_pkg::RQ_PEND),
		.o_expired(breq_exp)
	);
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			breq_exp_d <= 1'b0;
			o_breq_abort <= 1'b0;
		end else begin
			breq_exp_d <= breq_exp;
			o_breq_abort <= breq_exp && !breq_exp_d;
		end
	end

	// ==========================================================
	// DMA operation time limit while holding the bus
	vmeri_timer #(.LIMIT(DMA_CYC)) u_dma_timer (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_run(req_st == vmeri_pkg::RQ_OWN && dma_go),
		.o_expired(dma_exp)
	);
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || req_st != vmeri_pkg::RQ_OWN) begin
			o_dma_overrun <= 1'b0;
		end else if (dma_exp) begin
			o_dma_overrun <= 1'b1;
		end
	end

	// ==========================================================
	// interrupt pending flag; a new request beats the clear
	assign int_set = i_int_req && !int_req_d && run;
	assign iack_own = irq_pend && (i_iack_lvl == i_irq_level) &&
		(i_irq_level != `VMERI_IRQ_LVL_NONE);
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			int_req_d <= 1'b0;
			irq_pend <= 1'b0;
		end else begin
			int_req_d <= i_int_req;
			if (int_set) begin
				irq_pend <= 1'b1;
			end else if (ik_st == vmeri_pkg::IK_RESP) begin
				irq_pend <= 1'b0;
			end
		end
	end

	// ==========================================================
	// acknowledge chain: decided at chain entry, held until release
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ik_st <= vmeri_pkg::IK_IDLE;
		end else begin
			case (ik_st)
				vmeri_pkg::IK_IDLE: begin
					if (!i_iack_n && !i_iackin_n) begin
						ik_st <= iack_own ? vmeri_pkg::IK_RESP
							: vmeri_pkg::IK_PASS;
					end
				end
				default: begin
					if (i_iackin_n) begin
						ik_st <= vmeri_pkg::IK_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// interrupter pins
	always_comb begin
		for (int i = 1; i < 8; i++) begin
			o_irq_oe[i] = irq_pend && (i[2:0] == i_irq_level);
		end
	end
	assign o_irq_o = 7'h00;
	assign o_iackout_n = !(ik_st == vmeri_pkg::IK_PASS && !i_iackin_n);
	assign o_data_oe = (ik_st == vmeri_pkg::IK_RESP);

	// ==========================================================
	// status/ID byte, only taken while commands are accepted
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			status_id <= `VMERI_STATUS_ID_RST;
		end else if (i_cfg_wr && run) begin
			status_id <= i_cfg_status_id;
		end
	end
	assign o_data_o = status_id;

	// ==========================================================
	// watchdog: any kick restarts the count
	vmeri_timer #(.LIMIT(WDOG_CYC)) u_wdog_timer (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_run(run && !i_wdog_kick),
		.o_expired(wdog_exp)
	);

	// ==========================================================
	// supervision; failure is left only by system reset
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			sup_st <= vmeri_pkg::SUP_TEST;
		end else begin
			case (sup_st)
				vmeri_pkg::SUP_TEST: begin
					if (i_test_done) begin
						sup_st <= i_test_fault ? vmeri_pkg::SUP_FAIL
							: vmeri_pkg::SUP_CLEAR;
					end
				end
				vmeri_pkg::SUP_CLEAR: begin
					if (o_chan_addr == `VMERI_CHAN_LAST) begin
						sup_st <= vmeri_pkg::SUP_RUN;
					end
				end
				vmeri_pkg::SUP_RUN: begin
					if (wdog_exp || i_fw_fail) begin
						sup_st <= vmeri_pkg::SUP_FAIL;
					end
				end
				default: sup_st <= vmeri_pkg::SUP_FAIL;
			endcase
		end
	end

	// ==========================================================
	// channel sweep: every location but the last cleared, ready word written there last
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || sup_st != vmeri_pkg::SUP_CLEAR) begin
			o_chan_addr <= `VMERI_CHAN_FIRST;
			o_chan_data <= chan_word(`VMERI_CHAN_FIRST);
		end else if (o_chan_addr != `VMERI_CHAN_LAST) begin
			o_chan_addr <= o_chan_addr + 9'h001;
			o_chan_data <= chan_word(o_chan_addr + 9'h001);
		end
	end
	assign o_chan_we = (sup_st == vmeri_pkg::SUP_CLEAR);

	// ==========================================================
	// failure indication
	assign o_fail_led = (sup_st == vmeri_pkg::SUP_FAIL);
	assign o_sysfail_o = 1'b0;
	assign o_sysfail_oe = o_fail_led && i_sysfail_jmp;
	assign o_cmd_ready = run;
	assign o_test_run = (sup_st == vmeri_pkg::SUP_TEST);

	// ==========================================================
	// checks
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_granted;
		(req_st == vmeri_pkg::RQ_PEND) && bg_in;
	endsequence
	sequence s_strobe_free;
		(req_st == vmeri_pkg::RQ_SEIZE) && i_as_n;
	endsequence

	chk_req_raise: assert property (
		(req_st == vmeri_pkg::RQ_IDLE && dma_go && !bg_in)
			|=> o_br_oe[i_arb_level])
		else $error("bus request not raised");
	chk_req_held: assert property (
		(req_st == vmeri_pkg::RQ_PEND && !bg_in) |=> o_br_oe[i_arb_level])
		else $error("bus request dropped before grant");
	chk_seize_seq: assert property (
		s_granted ##1 s_strobe_free
			|=> o_bbsy_oe && !o_br_oe[i_arb_level])
		else $error("mastership not taken after strobe idle");
	chk_grant_excl: assert property (
		!(o_br_oe[i_arb_level] && !o_bg_out_n[i_arb_level]))
		else $error("grant passed while requesting");
	chk_pass_follow: assert property (
		(req_st == vmeri_pkg::RQ_PASS) |-> (o_bg_out_n[i_arb_level] == !bg_in))
		else $error("outgoing grant not following");
	chk_bus_release: assert property (
		(o_bbsy_oe && !dma_go && !bg_in) |=> !o_bbsy_oe && !o_master_en)
		else $error("bus not released");
	chk_breq_abort: assert property (
		$rose(breq_exp) |=> o_breq_abort ##1 !o_breq_abort)
		else $error("request timeout not reported once");
	chk_dma_limit: assert property (
		(o_master_en && dma_exp) |=> !o_master_en)
		else $error("DMA limit not enforced");
	chk_iack_own: assert property (
		(ik_st == vmeri_pkg::IK_IDLE && !i_iack_n && !i_iackin_n && iack_own
			&& !int_set) |=> o_data_oe ##1 !irq_pend)
		else $error("own acknowledge not answered");
	chk_iack_pass: assert property (
		(ik_st == vmeri_pkg::IK_PASS && !i_iackin_n) |-> !o_iackout_n)
		else $error("acknowledge not passed on");
	chk_fail_sticky: assert property (
		o_fail_led |=> o_fail_led && !o_cmd_ready)
		else $error("failure state left without reset");
	chk_wdog_fail: assert property (
		(run && wdog_exp) |=> o_fail_led)
		else $error("watchdog expiry not failing");
	chk_ready_word: assert property (
		(o_chan_we && o_chan_addr == `VMERI_CHAN_LAST)
			|-> o_chan_data == `VMERI_CHAN_READY ##1 o_cmd_ready)
		else $error("ready word not written last");

endmodule : vmeri_top

/* bench/vmeri_bus_model.sv */
// bus-side partner: arbiter, previous master strobe, ack daisy chain
// assumes the bench calls its tasks just after a falling edge
`timescale 1ns/1ps

module vmeri_bus_model (
	input wire logic i_core_clk, // core clock
	input wire logic [3:0] i_br_oe, // request drives
	input wire logic i_bbsy_oe, // busy drive
	output logic [3:0] o_bg_in_n, // grant chain in
	output logic o_as_n, // address strobe
	output logic o_iack_n, // ack cycle
	output logic o_iackin_n, // ack chain in
	output logic [2:0] o_iack_lvl // ack level
);
	int gdly = 2; // request to grant
	int slen = 2; // previous master tail
	int hdly = 2; // grant kept after busy
	bit arb_on = 1'b0; // bench enables arbitration
	int l = 0;

	// ==========================================================
	// arbiter
	// pulled-up lines idle high
	initial begin
		o_bg_in_n = 4'hF;
		o_as_n = 1'b1;
		o_iack_n = 1'b1;
		o_iackin_n = 1'b1;
		o_iack_lvl = 3'h0;
	end

	// grant lands while the previous master still strobes
	always begin
		@(negedge i_core_clk);
		if (arb_on && i_br_oe != 4'h0) begin
			for (int k = 0; k < 4; k++)
				if (i_br_oe[k]) l = k;
			repeat (gdly) @(negedge i_core_clk);
			o_as_n <= 1'b0;
			o_bg_in_n[l] <= 1'b0;
			repeat (slen) @(negedge i_core_clk);
			o_as_n <= 1'b1;
			// bounded: the requester may pass the grant instead
			for (int n = 0; n < 20 && !i_bbsy_oe; n++)
				@(negedge i_core_clk);
			repeat (hdly) @(negedge i_core_clk);
			o_bg_in_n[l] <= 1'b1;
			@(negedge i_core_clk);
		end
	end

	// ==========================================================
	// bench-commanded grant and ack cycles
	task automatic set_grant(input int lv, input logic v);
		o_bg_in_n[lv] <= v;
	endtask : set_grant

	// released level lines show a changed value, not the old one
	task automatic set_ack(input logic [2:0] lv, input logic on);
		o_iack_lvl <= on ? lv : ~o_iack_lvl;
		o_iack_n <= !on;
		o_iackin_n <= !on;
	endtask : set_ack

endmodule : vmeri_bus_model

/* bench/vmeri_top_tb_top.sv */
// self-checking bench of the requester/interrupter top
// assumes the partner model owns all bus-side inputs
`timescale 1ns/1ps
`include "vmeri_regs.svh"

module vmeri_top_tb_top;
	localparam int BQ = 20; // shortened request limit
	localparam int WD = 50; // shortened watchdog
	localparam int DM = 16; // shortened DMA limit
	logic clk = 1'b0, rst = 1'b1, jmp = 1'b0, dma = 1'b0, irq = 1'b0;
	logic cfg = 1'b0, kick = 1'b1, done = 1'b0, flt = 1'b0, ffl = 1'b0;
	logic [1:0] arb = 2'h0;
	logic [2:0] ilv = 3'h0, ilvl;
	logic [7:0] sid = 8'h00, dat, cd;
	logic [3:0] bgi, bgo, broe, br_q, bg_p;
	logic asn, iak, iin, iko, bboe, men, abt, ovr, doe, sfoe, led, trun;
	logic rdy, we, as_p, rst_p, bb_q;
	logic [7:1] iroe;
	logic [3:0] bro; // open-drain value pins, always low
	logic bbo, sfo;
	logic [7:1] iro;
	logic [8:0] ca;
	logic [31:0] seed = 32'h572C;
	int bad_count = 0, compares = 0, cyc = 0;

	always #2.5 clk = ~clk;

	vmeri_top #(.BREQ_CYC(BQ), .WDOG_CYC(WD), .DMA_CYC(DM)) vmeri_top_inst (
		.i_core_clk(clk), .i_sys_rst(rst), .i_arb_level(arb),
		.i_irq_level(ilv), .i_sysfail_jmp(jmp), .i_dma_req(dma),
		.i_int_req(irq), .i_cfg_wr(cfg), .i_cfg_status_id(sid),
		.i_wdog_kick(kick), .i_fw_fail(ffl), .i_test_done(done),
		.i_test_fault(flt), .i_bg_in_n(bgi), .i_as_n(asn), .i_iack_n(iak),
		.i_iackin_n(iin), .i_iack_lvl(ilvl), .o_bg_out_n(bgo), .o_br_o(bro),
		.o_br_oe(broe), .o_bbsy_o(bbo), .o_bbsy_oe(bboe), .o_master_en(men),
		.o_breq_abort(abt), .o_dma_overrun(ovr), .o_irq_o(iro),
		.o_irq_oe(iroe), .o_iackout_n(iko), .o_data_o(dat),
		.o_data_oe(doe), .o_sysfail_o(sfo), .o_sysfail_oe(sfoe),
		.o_fail_led(led), .o_test_run(trun), .o_cmd_ready(rdy),
		.o_chan_we(we), .o_chan_addr(ca), .o_chan_data(cd));

	vmeri_bus_model vmeri_bus_model_inst (
		.i_core_clk(clk), .i_br_oe(broe), .i_bbsy_oe(bboe),
		.o_bg_in_n(bgi), .o_as_n(asn), .o_iack_n(iak),
		.o_iackin_n(iin), .o_iack_lvl(ilvl));

	// ==========================================================
	// helpers
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask : check

	task automatic give_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// expected one-hot drive for a level
	function automatic logic [7:0] hot(input int lv);
		return 8'h01 << lv;
	endfunction : hot

	// expected channel word at the n-th sweep write
	function automatic logic [7:0] sweep_word(input int a);
		return (a == `VMERI_CHAN_LAST) ? `VMERI_CHAN_READY
			: `VMERI_CHAN_CLEAR;
	endfunction : sweep_word

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// ==========================================================
	// monitors
	// inputs as the design saw them at the rising edge
	always @(posedge clk) begin
		as_p <= asn;
		bg_p <= bgi;
		rst_p <= rst;
	end

	// drive changes judged against the inputs that caused them
	always @(negedge clk) begin
		if (!rst_p) begin
			if (bboe && !bb_q) check("strobe at seize", 1, as_p);
			if (bboe && !bb_q) check("req at seize", 0, broe[arb]);
			if (!bboe && bb_q) check("grant at release", 1, bg_p[arb]);
			if ((br_q & ~broe) != 4'h0) check("req drop", 0, |(br_q & bg_p));
			check("no pass while req", 0, broe & ~bgo);
			check("drive levels", 0, {bro, bbo, iro, sfo});
		end
		br_q = broe;
		bb_q = bboe;
	end

	// hang guard far above the roughly 1500 cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		int n;
		logic [7:0] s;
		tick(4);
		rst = 1'b0;
		check("test run", 1, trun);
		check("ready early", 0, rdy);
		tick(3);
		done = 1'b1;
		tick(1);
		done = 1'b0;
		n = 0;
		// no commands until the sweep has finished
		// the first write already stands when done is lowered
		for (int c = 0; c < 700 && !rdy; c++) begin
			if (we) begin
				check("sweep addr", n, ca);
				check("sweep data", sweep_word(n), cd);
				n++;
			end
			@(negedge clk);
		end
		check("sweep count", 512, n);
		check("ready after sweep", 2'b10, {rdy, we});
		vmeri_bus_model_inst.arb_on = 1'b1;
		// odd levels drop the DMA request early; the bus request still waits for the grant
		for (int l = 0; l < 5; l++) begin
			arb = 2'(l % 4);
			vmeri_bus_model_inst.gdly = 1 + rnd() % 6;
			vmeri_bus_model_inst.slen = 1 + rnd() % 4;
			vmeri_bus_model_inst.hdly = rnd() % 6;
			dma = 1'b1;
			tick(3);
			check("request level", hot(l % 4), broe);
			if (l % 2 == 1) dma = 1'b0;
			for (n = 0; n < 30 && broe !== 4'h0; n++) @(negedge clk);
			if (l % 2 == 0) begin
				check("busy", 1, bboe);
				check("master on", 1, men);
				tick(1 + rnd() % 8);
				// overrun only stands until the grant is seen negated
				if (l == 4) begin
					for (n = 0; n < DM + 12 && !ovr; n++) @(negedge clk);
					check("overrun", 1, ovr);
					check("master off", 0, men);
				end
				dma = 1'b0;
			end
			for (n = 0; n < 30 && (bboe || bgi !== 4'hF); n++) @(negedge clk);
			check("released", 0, {bboe, men});
		end
		vmeri_bus_model_inst.arb_on = 1'b0;
		dma = 1'b1;
		for (n = 0; n < 80 && !abt; n++) @(negedge clk);
		check("abort time", 1, n >= BQ && n <= BQ + 5);
		check("req kept", hot(arb), broe);
		dma = 1'b0;
		vmeri_bus_model_inst.arb_on = 1'b1;
		for (n = 0; n < 40 && (broe || bboe || bgi !== 4'hF); n++) @(negedge clk);
		vmeri_bus_model_inst.arb_on = 1'b0;
		tick(2);
		// unrequested grants on every level, jumper random
		for (int l = 0; l < 4; l++) begin
			arb = 2'(rnd() % 4);
			vmeri_bus_model_inst.set_grant(l, 1'b0);
			tick(3);
			check("grant passed", 4'hF ^ hot(l), bgo);
			vmeri_bus_model_inst.set_grant(l, 1'b1);
			tick(3);
			check("grant off", 4'hF, bgo);
		end
		for (int l = 1; l < 8; l++) begin
			ilv = 3'(l);
			void'(rnd());
			s = seed[7:0];
			sid = s;
			cfg = 1'b1;
			tick(1);
			cfg = 1'b0;
			irq = 1'b1;
			tick(2);
			check("irq drive", hot(l - 1), iroe);
			vmeri_bus_model_inst.set_ack(3'(l % 7 + 1), 1'b1);
			tick(3);
			check("ack passed", 0, {iko, doe});
			vmeri_bus_model_inst.set_ack(3'h0, 1'b0);
			tick(3);
			check("ack pass off", 1, iko);
			vmeri_bus_model_inst.set_ack(3'(l), 1'b1);
			tick(3);
			check("status id", {1'b1, s}, {doe, dat});
			check("irq dropped", 0, iroe);
			vmeri_bus_model_inst.set_ack(3'h0, 1'b0);
			irq = 1'b0;
			tick(3);
			check("id released", 0, doe);
		end
		// level zero switches the interrupter off
		ilv = 3'h0;
		irq = 1'b1;
		tick(2);
		check("irq off", 0, iroe);
		irq = 1'b0;
		jmp = 1'b1;
		kick = 1'b0;
		for (n = 0; n < 100 && !led; n++) @(negedge clk);
		check("watchdog time", 1, n >= WD && n <= WD + 4);
		check("fail drive", 1, sfoe);
		dma = 1'b1;
		tick(5);
		check("refused", 0, broe);
		dma = 1'b0;
		kick = 1'b1;
		rst = 1'b1;
		tick(4);
		rst = 1'b0;
		check("lamp reset", 0, led);
		// clean self-test, then a firmware fault stops the module
		done = 1'b1;
		tick(1);
		done = 1'b0;
		for (n = 0; n < 600 && !rdy; n++) @(negedge clk);
		check("ready again", 1, rdy);
		ffl = 1'b1;
		tick(1);
		ffl = 1'b0;
		check("firmware fail", 3'b101, {led, rdy, sfoe});
		rst = 1'b1;
		tick(4);
		rst = 1'b0;
		jmp = 1'b0;
		flt = 1'b1;
		done = 1'b1;
		tick(1);
		done = 1'b0;
		flt = 1'b0;
		tick(2);
		check("fault lamp", 1, led);
		check("fail drive off", 0, sfoe);
		give_verdict();
	end

endmodule : vmeri_top_tb_top
